/* bench/clock_mode_sva.sv */
/*
  Checker of the operating mode and system clock control block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps

module clock_mode_sva (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Register bus
  input wire clock_mode_pkg::apb_req_type apb_in,
  input wire clock_mode_pkg::apb_rsp_type apb_out,
  // Processor and oscillators
  input wire logic power_down_in,
  input wire logic wake_in,
  input wire logic watchdog_enable_in,
  input wire logic fast_osc_ready_in,
  input wire logic slow_osc_ready_in,
  input wire logic low_speed_clock_in,
  // Clock controls
  input wire logic cpu_run_out,
  input wire logic sys_clk_tick_out,
  input wire logic high_speed_clock_on_out,
  input wire logic low_speed_clock_on_out,
  input wire logic fast_osc_run_out,
  input wire logic slow_osc_run_out,
  input wire logic irq_out
);
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  AST_ANSWER_NEXT: assert property (apb_in.psel && apb_in.penable && !apb_out.pready |=> apb_out.pready)
    else $error("no answer one cycle after access");
  AST_PREADY_ONE: assert property (apb_out.pready |=> !apb_out.pready)
    else $error("ready stands longer than one cycle");
  AST_RDATA_IDLE: assert property (!apb_out.pready |-> apb_out.prdata == 32'h00000000)
    else $error("read data not zero outside answer");
  AST_ERR_READY: assert property (apb_out.pslverr |-> apb_out.pready && apb_out.prdata == 32'h00000000)
    else $error("error without ready or with data");
  AST_HALT_STOPS: assert property ($fell(cpu_run_out) |-> $past(power_down_in))
    else $error("processor stopped without halt");
  AST_NO_TICK_ALL_OFF: assert property (sys_clk_tick_out |->
    cpu_run_out || high_speed_clock_on_out || low_speed_clock_on_out || $past(cpu_run_out))
    else $error("system tick while all clocks stopped");
  AST_FAST_NEEDS_OSC: assert property (high_speed_clock_on_out |-> fast_osc_run_out || $past(fast_osc_run_out))
    else $error("fast clock on with oscillator off");
  AST_SLOW_NEEDS_OSC: assert property (low_speed_clock_on_out |-> slow_osc_run_out || $past(slow_osc_run_out))
    else $error("slow clock on with oscillator off");
  AST_SLOW_OSC_OFF: assert property ($fell(slow_osc_run_out) |-> !cpu_run_out)
    else $error("slow oscillator stopped while running");

  COV_ERR: cover property (apb_out.pslverr);
  COV_HALT: cover property ($fell(cpu_run_out));
  COV_IRQ: cover property ($rose(irq_out));
  COV_SOSC_OFF: cover property ($fell(slow_osc_run_out));
endmodule

/* bench/operating_mode_clock_control_bench.sv */
/*
  Self-checking bench of the operating mode and system clock control block.
  Assumes the package and the constants header are compiled first.
*/
`timescale 1ns/1ps
`include "clock_mode_defs.svh"

module operating_mode_clock_control_bench;
  logic ref_clk_in, rst_b_in, power_down_in, wake_in, watchdog_enable_in;
  logic fast_osc_ready_in, slow_osc_ready_in, low_speed_clock_in;
  clock_mode_pkg::apb_req_type apb_in;
  clock_mode_pkg::apb_rsp_type apb_out;
  logic cpu_run_out, sys_clk_tick_out, high_speed_clock_on_out, low_speed_clock_on_out;
  logic fast_osc_run_out, slow_osc_run_out, irq_out, err;
  logic [31:0] rd, r;
  int num_errors, check_count, seed, cyc, lsc, s, old, t0, p;

  operating_mode_clock_control i_dut (
    .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .apb_in(apb_in), .apb_out(apb_out),
    .power_down_in(power_down_in), .wake_in(wake_in), .watchdog_enable_in(watchdog_enable_in),
    .fast_osc_ready_in(fast_osc_ready_in), .slow_osc_ready_in(slow_osc_ready_in),
    .low_speed_clock_in(low_speed_clock_in), .cpu_run_out(cpu_run_out), .sys_clk_tick_out(sys_clk_tick_out),
    .high_speed_clock_on_out(high_speed_clock_on_out), .low_speed_clock_on_out(low_speed_clock_on_out),
    .fast_osc_run_out(fast_osc_run_out), .slow_osc_run_out(slow_osc_run_out), .irq_out(irq_out)
  );

  initial
  begin
    ref_clk_in = 1'h0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  // Slow clock, 16 reference cycles a period
  always @(posedge ref_clk_in)
  begin
    cyc <= cyc + 1;
    lsc <= (lsc + 1) % 16;
    low_speed_clock_in <= (lsc >= 8);
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic fail;
    num_errors++;
    conclude();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    apb_in <= '{psel: 1'h1, penable: 1'h0, pwrite: w, paddr: a, pwdata: wd};
    @(posedge ref_clk_in);
    apb_in.penable <= 1'h1;
    do
    begin
      @(posedge ref_clk_in);
      n++;
    end
    while (apb_out.pready !== 1'h1 && n < 20);
    rd = apb_out.prdata;
    err = apb_out.pslverr;
    apb_in.psel <= 1'h0;
    apb_in.penable <= 1'h0;
    if (apb_out.pready !== 1'h1)
      fail();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
    xfer(1'h0, a, 32'h00000000);
    chk(rd, exp);
    chk(err, exp_err);
  endtask

  task automatic wait_run(input logic [2:0] sel);
    int n;
    n = 0;
    do
    begin
      xfer(1'h0, `OFS_MODE_STATUS, 32'h00000000);
      n++;
    end
    while (!(rd[10:8] === sel && rd[5:0] === 6'h01) && n < 300);
    if (n >= 300)
      fail();
  endtask

  task automatic tick_period(output int per);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    while (sys_clk_tick_out !== 1'h1 && n < 200)
    begin
      @(posedge ref_clk_in);
      n++;
    end
    per = 0;
    do
    begin
      @(posedge ref_clk_in);
      per++;
    end
    while (sys_clk_tick_out !== 1'h1 && per < 200);
  endtask

  task automatic halt_all(input logic [2:0] sel);
    logic [1:0] idl;
    logic wd;
    int t;
    for (int i = 0; i < 4; i++)
    begin
      idl = i[1:0];
      wd = $random(seed);
      xfer(1'h1, `OFS_SYSTEM_CLOCK_CONFIG, {24'h000000, sel, 3'h0, idl});
      wait_run(sel);
      watchdog_enable_in <= wd;
      power_down_in <= 1'h1;
      @(posedge ref_clk_in);
      power_down_in <= 1'h0;
      repeat (6) @(posedge ref_clk_in);
      t = 0;
      for (int k = 0; k < 48; k++)
      begin
        @(posedge ref_clk_in);
        t += (sys_clk_tick_out === 1'h1);
      end
      chk(cpu_run_out, 1'h0);
      chk(high_speed_clock_on_out, idl[1]);
      chk(low_speed_clock_on_out, idl[0]);
      chk(fast_osc_run_out, idl[1]);
      chk(t > 0, (sel == 3'h7) ? idl[0] : idl[1]);
      chk(slow_osc_run_out, idl != 2'h0 || wd);
      wake_in <= 1'h1;
      @(posedge ref_clk_in);
      wake_in <= 1'h0;
      wait_run(sel);
    end
  endtask

  initial
  begin
    repeat (100000) @(posedge ref_clk_in);
    fail();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    seed = 9;
    num_errors = 0;
    check_count = 0;
    cyc = 0;
    lsc = 0;
    rst_b_in = 1'h0;
    apb_in = '0;
    power_down_in = 1'h0;
    wake_in = 1'h0;
    watchdog_enable_in = 1'h0;
    fast_osc_ready_in = 1'h1;
    slow_osc_ready_in = 1'h1;
    low_speed_clock_in = 1'h0;
    repeat (5) @(posedge ref_clk_in);
    rst_b_in <= 1'h1;
    rd_chk(`OFS_SYSTEM_CLOCK_CONFIG, 32'h00000000, 1'h0);
    xfer(1'h0, `OFS_FAST_OSC_CTRL, 32'h00000000);
    chk(rd & 32'hfffffffd, 32'h00000001);
    rd_chk(`OFS_IRQ_MASK, 32'h00000000, 1'h0);
    rd_chk(8'(({$random(seed)} % 59 + 5) * 4), 32'h00000000, 1'h1);
    r = $random(seed);
    xfer(1'h1, `OFS_SYSTEM_CLOCK_CONFIG, r & 32'hffffff1f);
    rd_chk(`OFS_SYSTEM_CLOCK_CONFIG, r & 32'h00000003, 1'h0);
    $display("registers test done");
    old = 0;
    for (s = 0; s < 8; s++)
    begin
      if (s == 7)
        slow_osc_ready_in <= 1'h0;
      t0 = cyc;
      xfer(1'h1, `OFS_SYSTEM_CLOCK_CONFIG, {24'h000000, s[2:0], 5'h00});
      if (s == 7)
      begin
        repeat (300) @(posedge ref_clk_in);
        xfer(1'h0, `OFS_MODE_STATUS, 32'h00000000);
        chk(rd[10:0], 11'h602);
        slow_osc_ready_in <= 1'h1;
      end
      wait_run(s[2:0]);
      if (s < 7)
        chk(cyc - t0 <= 4 * (1 << old) + 2 * (1 << s) + 40, 1'h1);
      tick_period(p);
      chk(p, (s == 7) ? 16 : (1 << s));
      old = s;
    end
    $display("clock select test done");
    xfer(1'h0, `OFS_IRQ_STATUS, 32'h00000000);
    chk(rd & 32'h00000001, 32'h00000001);
    rd_chk(`OFS_IRQ_STATUS, 32'h00000000, 1'h0);
    xfer(1'h1, `OFS_IRQ_MASK, 32'h00000002);
    xfer(1'h1, `OFS_FAST_OSC_CTRL, 32'h00000000);
    fast_osc_ready_in <= 1'h0;
    repeat (4) @(posedge ref_clk_in);
    chk(fast_osc_run_out, 1'h0);
    chk(high_speed_clock_on_out, 1'h0);
    rd_chk(`OFS_FAST_OSC_CTRL, 32'h00000000, 1'h0);
    xfer(1'h1, `OFS_FAST_OSC_CTRL, 32'h00000003);
    rd_chk(`OFS_FAST_OSC_CTRL, 32'h00000001, 1'h0);
    chk(irq_out, 1'h0);
    fast_osc_ready_in <= 1'h1;
    repeat (8) @(posedge ref_clk_in);
    chk(fast_osc_run_out, 1'h1);
    rd_chk(`OFS_FAST_OSC_CTRL, 32'h00000003, 1'h0);
    chk(irq_out, 1'h1);
    xfer(1'h0, `OFS_IRQ_STATUS, 32'h00000000);
    chk(rd & 32'h00000002, 32'h00000002);
    repeat (2) @(posedge ref_clk_in);
    chk(irq_out, 1'h0);
    $display("fast oscillator test done");
    halt_all(3'h7);
    halt_all(3'h0);
    $display("halt test done");
    conclude();
  end
endmodule

bind operating_mode_clock_control clock_mode_sva i_sva (
  .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .apb_in(apb_in), .apb_out(apb_out),
  .power_down_in(power_down_in), .wake_in(wake_in), .watchdog_enable_in(watchdog_enable_in),
  .fast_osc_ready_in(fast_osc_ready_in), .slow_osc_ready_in(slow_osc_ready_in),
  .low_speed_clock_in(low_speed_clock_in), .cpu_run_out(cpu_run_out), .sys_clk_tick_out(sys_clk_tick_out),
  .high_speed_clock_on_out(high_speed_clock_on_out), .low_speed_clock_on_out(low_speed_clock_on_out),
  .fast_osc_run_out(fast_osc_run_out), .slow_osc_run_out(slow_osc_run_out), .irq_out(irq_out)
);

/* hw/operating_mode_clock_control.sv */
/*
  Operating mode and system clock control: selects the system clock
  (fast source divided by 1 to 64, or the slow source), runs the clock
  handover, the halt power-down modes and the fast oscillator stable flag.
  Assumes ref_clk_in is the fast RC oscillator output, oscillator ready
  levels and the slow clock arrive asynchronously, and the processor
  gives a one-cycle halt pulse and a one-cycle wake pulse.

// Function
// - Selector codes 000-110 give fast clock divided 1..64; 111 gives slow clock.
// - Fast mode: processor runs on fast oscillator divided by 1 up to 64.
// - Writing 111 in fast mode moves processor to slow mode on slow clock.
// - Handover to slow source waits until slow oscillator is stable.
// - In slow mode fast clock runs or stops per fast oscillator enable.
// - Halt with both idle enables 0: sleep, processor and both clocks stop.
// - In sleep the slow oscillator runs only while the watchdog is enabled.
// - Halt with idle enables 0/1: slow-only idle, fast stops, sys only if 111.
// - Halt with both idle enables 1: processor stops, all clocks keep running.
// - Halt with idle enables 1/0: fast-only idle, slow stops, sys only for 000-110.
// - Config register: selector bits 7-5, idle enables bits 1,0; rest zero; reset 0.
// - Enabling fast oscillator clears stable flag, sets it once oscillator stable.
// - Enable bit 0 resets 1; read-only stable flag bit 1 resets 0.
// - Handover within 4 current system periods plus source alignment; software waits.
*/
`timescale 1ns/1ps
`include "clock_mode_defs.svh"

module operating_mode_clock_control (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Register bus
  input wire clock_mode_pkg::apb_req_type apb_in,
  output clock_mode_pkg::apb_rsp_type apb_out,
  // Processor and watchdog
  input wire logic power_down_in,
  input wire logic wake_in,
  input wire logic watchdog_enable_in,
  // Oscillators
  input wire logic fast_osc_ready_in,
  input wire logic slow_osc_ready_in,
  input wire logic low_speed_clock_in,
  // Clock controls
  output logic cpu_run_out,
  output logic sys_clk_tick_out,
  output logic high_speed_clock_on_out,
  output logic low_speed_clock_on_out,
  output logic fast_osc_run_out,
  output logic slow_osc_run_out,
  // Interrupt
  output logic irq_out
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic clock_mode_pkg::reg_sel_type decode_addr(input logic [7:0] addr);
    clock_mode_pkg::reg_sel_type r;
    case (addr)
      `OFS_SYSTEM_CLOCK_CONFIG: r = clock_mode_pkg::REG_CFG;
      `OFS_FAST_OSC_CTRL: r = clock_mode_pkg::REG_FOC;
      `OFS_IRQ_STATUS: r = clock_mode_pkg::REG_IRQ_STATUS;
      `OFS_IRQ_MASK: r = clock_mode_pkg::REG_IRQ_MASK;
      `OFS_MODE_STATUS: r = clock_mode_pkg::REG_MODE_STATUS;
      default: r = clock_mode_pkg::REG_NONE;
    endcase
    return r;
  endfunction

  // Divider tick for a fast selector code, slow edge for code 111
  function automatic logic source_tick(input logic [2:0] code, input logic [5:0] cnt,
                                       input logic slow_edge);
    logic [5:0] mask;
    mask = 6'((`DIV_MASK_ONE << code) - `DIV_MASK_ONE);
    if (code == `SEL_SLOW)
    begin
      return slow_edge;
    end
    return (cnt & mask) == `DIV_CNT_ZERO;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  clock_mode_pkg::state_type s_q;
  clock_mode_pkg::state_type s_d;

  logic access;
  logic slow_edge;
  logic cur_tick;
  logic tgt_tick;
  logic tgt_ready;
  logic fast_req;
  logic fosc_rise;
  logic sys_slow;
  logic [2:0] events;
  clock_mode_pkg::reg_sel_type rsel;

  always_comb
  begin
    s_d = s_q;
    events = `IRQ_RESET;
    access = apb_in.psel & apb_in.penable & s_q.pready;
    rsel = decode_addr(apb_in.paddr);
    fosc_rise = 1'h0;

    // Three-stage input synchronisers, level follows when stages 2 and 3 agree
    s_d.fr_sync = {s_q.fr_sync[1:0], fast_osc_ready_in};
    s_d.sr_sync = {s_q.sr_sync[1:0], slow_osc_ready_in};
    s_d.lc_sync = {s_q.lc_sync[1:0], low_speed_clock_in};
    if (s_q.fr_sync[1] == s_q.fr_sync[2])
    begin
      s_d.fr_level = s_q.fr_sync[2];
    end
    if (s_q.sr_sync[1] == s_q.sr_sync[2])
    begin
      s_d.sr_level = s_q.sr_sync[2];
    end
    if (s_q.lc_sync[1] == s_q.lc_sync[2])
    begin
      s_d.lc_level = s_q.lc_sync[2];
    end
    slow_edge = s_d.lc_level & ~s_q.lc_level;

    // Fast clock divider
    s_d.div_cnt = 6'(s_q.div_cnt + `DIV_CNT_STEP);
    cur_tick = source_tick(s_q.act_sel, s_q.div_cnt, slow_edge);
    tgt_tick = source_tick(s_q.sel, s_q.div_cnt, slow_edge);
    tgt_ready = (s_q.sel == `SEL_SLOW) ? s_q.sr_level : (s_q.fr_level & s_q.fosc_run);

    // ****************************************************************
    // Register writes
    // ****************************************************************
    if (access && apb_in.pwrite)
    begin
      case (rsel)
        clock_mode_pkg::REG_CFG:
        begin
          s_d.sel = apb_in.pwdata[`CFG_SEL_HI:`CFG_SEL_LO];
          s_d.hi_idle = apb_in.pwdata[`CFG_HI_IDLE_BIT];
          s_d.lo_idle = apb_in.pwdata[`CFG_LO_IDLE_BIT];
        end
        clock_mode_pkg::REG_FOC:
        begin
          s_d.fosc_en = apb_in.pwdata[`FOC_ENABLE_BIT];
          fosc_rise = apb_in.pwdata[`FOC_ENABLE_BIT] & ~s_q.fosc_en;
        end
        clock_mode_pkg::REG_IRQ_MASK:
        begin
          s_d.irq_mask = apb_in.pwdata[`IRQ_FIELD_HI:`FIELD_LO];
        end
        default:
        begin
        end
      endcase
    end

    // ****************************************************************
    // Operating mode sequencing
    // ****************************************************************
    case (s_q.mode)
      clock_mode_pkg::MODE_RUN:
      begin
        if (power_down_in)
        begin
          case ({s_q.hi_idle, s_q.lo_idle})
            2'h0: s_d.mode = clock_mode_pkg::MODE_SLEEP;
            2'h1: s_d.mode = clock_mode_pkg::MODE_IDLE_SLOW_ONLY;
            2'h3: s_d.mode = clock_mode_pkg::MODE_IDLE_BOTH_CLOCKS;
            default: s_d.mode = clock_mode_pkg::MODE_IDLE_FAST_ONLY;
          endcase
          events[`IRQ_POWER_DOWN_BIT] = 1'h1;
        end
        else if (s_q.sel != s_q.act_sel)
        begin
          s_d.mode = clock_mode_pkg::MODE_SWITCH;
          s_d.sw_cnt = `SWITCH_CNT_RESET;
        end
      end
      clock_mode_pkg::MODE_SWITCH:
      begin
        if (s_q.sel == s_q.act_sel)
        begin
          s_d.mode = clock_mode_pkg::MODE_RUN;
        end
        else if (s_q.sw_cnt != `SWITCH_SYS_PERIODS)
        begin
          if (cur_tick)
          begin
            s_d.sw_cnt = 3'(s_q.sw_cnt + `SWITCH_CNT_STEP);
          end
        end
        else if (tgt_ready && tgt_tick)
        begin
          s_d.act_sel = s_q.sel;
          s_d.mode = clock_mode_pkg::MODE_RUN;
          events[`IRQ_SWITCH_DONE_BIT] = 1'h1;
        end
      end
      clock_mode_pkg::MODE_SLEEP,
      clock_mode_pkg::MODE_IDLE_SLOW_ONLY,
      clock_mode_pkg::MODE_IDLE_BOTH_CLOCKS,
      clock_mode_pkg::MODE_IDLE_FAST_ONLY:
      begin
        if (wake_in)
        begin
          s_d.mode = clock_mode_pkg::MODE_RUN;
        end
      end
      default:
      begin
        s_d.mode = clock_mode_pkg::MODE_RUN;
      end
    endcase

    // ****************************************************************
    // Clock gating per mode
    // ****************************************************************
    sys_slow = (s_d.act_sel == `SEL_SLOW);
    fast_req = ~sys_slow | (s_d.sel != `SEL_SLOW) | s_d.fosc_en;
    s_d.cpu_run = 1'h0;
    s_d.sys_tick = 1'h0;
    s_d.fosc_run = 1'h0;
    s_d.sosc_run = 1'h1;
    s_d.ls_on = 1'h0;
    case (s_d.mode)
      clock_mode_pkg::MODE_RUN,
      clock_mode_pkg::MODE_SWITCH:
      begin
        s_d.cpu_run = 1'h1;
        s_d.sys_tick = cur_tick;
        s_d.fosc_run = fast_req;
        s_d.ls_on = 1'h1;
      end
      clock_mode_pkg::MODE_SLEEP:
      begin
        s_d.sosc_run = watchdog_enable_in;
      end
      clock_mode_pkg::MODE_IDLE_SLOW_ONLY:
      begin
        s_d.sys_tick = cur_tick & sys_slow;
        s_d.ls_on = 1'h1;
      end
      clock_mode_pkg::MODE_IDLE_BOTH_CLOCKS:
      begin
        s_d.sys_tick = cur_tick;
        s_d.fosc_run = 1'h1;
        s_d.ls_on = 1'h1;
      end
      clock_mode_pkg::MODE_IDLE_FAST_ONLY:
      begin
        s_d.sys_tick = cur_tick & ~sys_slow;
        s_d.fosc_run = 1'h1;
      end
      default:
      begin
      end
    endcase
    s_d.hs_on = s_d.fosc_run & s_q.fr_level;
    s_d.ls_on = s_d.ls_on & s_q.sr_level;

    // ****************************************************************
    // Fast oscillator stable flag
    // ****************************************************************
    if (fosc_rise || !s_d.fosc_en)
    begin
      s_d.fosc_flag = 1'h0;
    end
    else if (s_q.fosc_run && s_q.fr_level)
    begin
      s_d.fosc_flag = 1'h1;
    end
    events[`IRQ_FAST_STABLE_BIT] = s_d.fosc_flag & ~s_q.fosc_flag;

    // ****************************************************************
    // Read answer and read-to-clear status
    // ****************************************************************
    s_d.pready = apb_in.psel & apb_in.penable & ~s_q.pready;
    s_d.pslverr = 1'h0;
    s_d.prdata = `WORD_ZERO;
    if (s_d.pready)
    begin
      s_d.pslverr = (rsel == clock_mode_pkg::REG_NONE);
      case (rsel)
        clock_mode_pkg::REG_CFG:
        begin
          s_d.prdata[`CFG_SEL_HI:`CFG_SEL_LO] = s_q.sel;
          s_d.prdata[`CFG_HI_IDLE_BIT] = s_q.hi_idle;
          s_d.prdata[`CFG_LO_IDLE_BIT] = s_q.lo_idle;
        end
        clock_mode_pkg::REG_FOC:
        begin
          s_d.prdata[`FOC_ENABLE_BIT] = s_q.fosc_en;
          s_d.prdata[`FOC_FLAG_BIT] = s_q.fosc_flag;
        end
        clock_mode_pkg::REG_IRQ_STATUS:
        begin
          s_d.prdata[`IRQ_FIELD_HI:`FIELD_LO] = s_q.irq_stat;
        end
        clock_mode_pkg::REG_IRQ_MASK:
        begin
          s_d.prdata[`IRQ_FIELD_HI:`FIELD_LO] = s_q.irq_mask;
        end
        clock_mode_pkg::REG_MODE_STATUS:
        begin
          s_d.prdata[`MODE_FIELD_HI:`FIELD_LO] = s_q.mode;
          s_d.prdata[`ACT_SEL_HI:`ACT_SEL_LO] = s_q.act_sel;
        end
        default:
        begin
        end
      endcase
    end
    // Set wins over the read clear
    if (access && !apb_in.pwrite && rsel == clock_mode_pkg::REG_IRQ_STATUS)
    begin
      s_d.irq_stat = events;
    end
    else
    begin
      s_d.irq_stat = s_q.irq_stat | events;
    end
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_b_in)
    begin
      s_q.sel <= `CFG_SEL_RESET;
      s_q.hi_idle <= `CFG_IDLE_RESET;
      s_q.lo_idle <= `CFG_IDLE_RESET;
      s_q.fosc_en <= `FOC_ENABLE_RESET;
      s_q.fosc_flag <= `FOC_FLAG_RESET;
      s_q.act_sel <= `CFG_SEL_RESET;
      s_q.mode <= clock_mode_pkg::MODE_RUN;
      s_q.sw_cnt <= `SWITCH_CNT_RESET;
      s_q.div_cnt <= `DIV_CNT_RESET;
      s_q.fr_sync <= `SYNC_RESET;
      s_q.fr_level <= 1'h0;
      s_q.sr_sync <= `SYNC_RESET;
      s_q.sr_level <= 1'h0;
      s_q.lc_sync <= `SYNC_RESET;
      s_q.lc_level <= 1'h0;
      s_q.irq_stat <= `IRQ_RESET;
      s_q.irq_mask <= `IRQ_RESET;
      s_q.irq <= 1'h0;
      s_q.pready <= 1'h0;
      s_q.pslverr <= 1'h0;
      s_q.prdata <= `WORD_ZERO;
      s_q.cpu_run <= 1'h0;
      s_q.sys_tick <= 1'h0;
      s_q.hs_on <= 1'h0;
      s_q.ls_on <= 1'h0;
      s_q.fosc_run <= 1'h1;
      s_q.sosc_run <= 1'h1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs, all from flip-flops
  // ****************************************************************
  assign apb_out.pready = s_q.pready;
  assign apb_out.pslverr = s_q.pslverr;
  assign apb_out.prdata = s_q.prdata;
  assign cpu_run_out = s_q.cpu_run;
  assign sys_clk_tick_out = s_q.sys_tick;
  assign high_speed_clock_on_out = s_q.hs_on;
  assign low_speed_clock_on_out = s_q.ls_on;
  assign fast_osc_run_out = s_q.fosc_run;
  assign slow_osc_run_out = s_q.sosc_run;
  assign irq_out = s_q.irq;

endmodule

/* inc/clock_mode_defs.svh */
/*
  Constants of the operating mode and system clock control block:
  register byte offsets, field positions, reset values, counts.
  Assumes inclusion by its bare name from the design files.
*/
`ifndef CLOCK_MODE_DEFS_SVH
`define CLOCK_MODE_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_SYSTEM_CLOCK_CONFIG 8'h00
`define OFS_FAST_OSC_CTRL 8'h04
`define OFS_IRQ_STATUS 8'h08
`define OFS_IRQ_MASK 8'h0c
`define OFS_MODE_STATUS 8'h10

// ****************************************************************
// Field positions
// ****************************************************************
`define CFG_SEL_HI 7
`define CFG_SEL_LO 5
`define CFG_HI_IDLE_BIT 1
`define CFG_LO_IDLE_BIT 0
`define FOC_ENABLE_BIT 0
`define FOC_FLAG_BIT 1
`define IRQ_SWITCH_DONE_BIT 0
`define IRQ_FAST_STABLE_BIT 1
`define IRQ_POWER_DOWN_BIT 2
`define IRQ_FIELD_HI 2
`define MODE_FIELD_HI 5
`define ACT_SEL_HI 10
`define ACT_SEL_LO 8
`define FIELD_LO 0

// ****************************************************************
// Reset values and codes
// ****************************************************************
`define CFG_SEL_RESET 3'h0
`define CFG_IDLE_RESET 1'h0
`define FOC_ENABLE_RESET 1'h1
`define FOC_FLAG_RESET 1'h0
`define IRQ_RESET 3'h0
`define SEL_SLOW 3'h7
`define SWITCH_SYS_PERIODS 3'h4
`define SWITCH_CNT_RESET 3'h0
`define DIV_CNT_RESET 6'h00
`define SYNC_RESET 3'h0
`define DIV_MASK_ONE 6'h01
`define DIV_CNT_ZERO 6'h00
`define DIV_CNT_STEP 6'h01
`define SWITCH_CNT_STEP 3'h1
`define WORD_ZERO 32'h00000000

`endif

/* inc/clock_mode_pkg.sv */
/*
  Types of the operating mode and system clock control block:
  the APB carrier structs, the mode enumeration and the state record.
  Assumes the constants header is compiled alongside.
*/
package clock_mode_pkg;

  // ****************************************************************
  // APB carriers
  // ****************************************************************
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_type;

  // ****************************************************************
  // Operating mode, one-hot
  // ****************************************************************
  typedef enum logic [5:0] {
    MODE_RUN = 6'h01,
    MODE_SWITCH = 6'h02,
    MODE_SLEEP = 6'h04,
    MODE_IDLE_SLOW_ONLY = 6'h08,
    MODE_IDLE_BOTH_CLOCKS = 6'h10,
    MODE_IDLE_FAST_ONLY = 6'h20
  } mode_type;

  typedef enum logic [2:0] {
    REG_CFG = 3'h0,
    REG_FOC = 3'h1,
    REG_IRQ_STATUS = 3'h2,
    REG_IRQ_MASK = 3'h3,
    REG_MODE_STATUS = 3'h4,
    REG_NONE = 3'h7
  } reg_sel_type;

  // ****************************************************************
  // Whole state of the block
  // ****************************************************************
  typedef struct packed {
    logic [2:0] sel;
    logic hi_idle;
    logic lo_idle;
    logic fosc_en;
    logic fosc_flag;
    logic [2:0] act_sel;
    mode_type mode;
    logic [2:0] sw_cnt;
    logic [5:0] div_cnt;
    logic [2:0] fr_sync;
    logic fr_level;
    logic [2:0] sr_sync;
    logic sr_level;
    logic [2:0] lc_sync;
    logic lc_level;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic cpu_run;
    logic sys_tick;
    logic hs_on;
    logic ls_on;
    logic fosc_run;
    logic sosc_run;
  } state_type;

endpackage
